// [core/drive_sel_defs.svh]
// Register map, field positions and reset values for drive select logic
`ifndef DRIVE_SEL_DEFS_SVH
`define DRIVE_SEL_DEFS_SVH

`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04

`define CTRL_UNIT_LSB 0
`define CTRL_UNIT_MSB 2
`define CTRL_FAULT_CLR 8

`define ST_SELECTED 0
`define ST_SEL_READY 1
`define ST_PROTECT 2
`define ST_FAULT 3
`define ST_TOGGLE 4
`define ST_UNSAFE 5
`define ST_LOADED 6

`define UNIT_RST 3'h0
`define SYNC_W 13

`endif

// [core/drive_sel_pkg.sv]
// Shared types for the drive select and status logic
package drive_sel_pkg;
  typedef logic [31:0] word_t;
  typedef logic [2:0] unit_t;
  typedef logic [3:0] sel_lines_t;
  typedef logic [3:0] sector_t;
endpackage : drive_sel_pkg

// [core/drive_select_status_logic.sv]
// Drive-side select, status, protect and fault logic with an APB slave
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "drive_sel_defs.svh"

module drive_select_status_logic (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interface cable inputs (asynchronous)
  input wire logic [3:0] drive_select_in,
  input wire logic octal_select_mode,
  input wire logic write_enable_in,
  input wire logic protect_set_in,
  input wire logic read_enable_in,
  // Front panel and supply monitors (asynchronous)
  input wire logic protect_button_pressed,
  input wire logic protect_button_released,
  input wire logic [2:0] supply_abnormal,
  // Drive internal logic, same clock
  input wire logic heads_loaded,
  input wire logic fwd_req,
  input wire logic rev_req,
  input wire logic write_current,
  input wire logic read_data_in,
  input wire logic read_clock_in,
  input wire logic [3:0] sector_count_in,
  input wire logic seek_settled_in,
  input wire logic seek_timeout_in,
  // Interface cable responses
  output logic density_flag_out,
  output logic file_ready_resp,
  output logic write_check_resp,
  output logic protect_status_resp,
  output logic [3:0] sector_count_out,
  output logic seek_settled_resp,
  output logic seek_timeout_resp,
  output logic read_data_out,
  output logic read_clock_out,
  // Drive internal controls
  output logic selected_write_enable,
  output logic write_toggle_en,
  output logic strobe_delay_en,
  output logic head_deselect,
  output logic unsafe_trip,
  // Front panel lamps
  output logic on_cyl_lamp,
  output logic read_lamp,
  output logic write_lamp,
  output logic protect_lamp
);

  function automatic logic unit_match(
    input drive_sel_pkg::sel_lines_t lines,
    input logic octal,
    input drive_sel_pkg::unit_t unit
  );
    logic hit;
    hit = 1'b0;
    if (octal) begin
      hit = (lines[2:0] == unit);
    end else if (unit[2] == 1'b0) begin
      hit = lines[unit[1:0]];
    end
    return hit;
  endfunction : unit_match

  // Two-stage synchroniser for everything arriving from outside pclk
  logic [`SYNC_W-1:0] meta_ff;
  logic [`SYNC_W-1:0] sync_ff;
  logic [`SYNC_W-1:0] nxt_meta;
  logic [`SYNC_W-1:0] nxt_sync;
  logic [`SYNC_W-1:0] raw_in;

  assign raw_in = {drive_select_in, octal_select_mode, write_enable_in,
                   protect_set_in, read_enable_in, protect_button_pressed,
                   protect_button_released, supply_abnormal};

  always_comb begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    if (ce) begin
      nxt_meta = raw_in;
      nxt_sync = meta_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  drive_sel_pkg::sel_lines_t sel_lines_s;
  logic octal_s, wen_s, pset_s, ren_s, btn_on_s, btn_off_s;
  logic [2:0] supply_s;

  assign {sel_lines_s, octal_s, wen_s, pset_s, ren_s, btn_on_s, btn_off_s,
          supply_s} = sync_ff;

  // Software-visible control
  drive_sel_pkg::unit_t unit_ff;
  drive_sel_pkg::unit_t nxt_unit;
  logic fault_clr;
  logic wr_acc;

  // Core latches
  logic protect_ff, fault_ff, toggle_ff;
  logic nxt_protect, nxt_fault, nxt_toggle;

  logic selected;
  logic sel_ready;
  logic sel_read;
  logic sel_write;
  logic no_motion;
  logic unsafe_set;
  logic unsafe;

  assign selected = unit_match(sel_lines_s, octal_s, unit_ff);
  assign sel_ready = selected && heads_loaded && !fault_ff;
  assign sel_read = sel_ready && ren_s;
  assign sel_write = sel_ready && wen_s;
  assign no_motion = !fwd_req && !rev_req;
  assign unsafe_set = write_current && !wen_s;
  assign unsafe = (|supply_s) || fault_ff || !heads_loaded;

  always_comb begin
    nxt_protect = protect_ff;
    nxt_fault = fault_ff;
    nxt_toggle = toggle_ff;
    if (ce) begin
      if (btn_on_s) begin
        nxt_toggle = 1'b1;
        if (!toggle_ff) begin
          nxt_protect = !protect_ff;
        end
        nxt_fault = 1'b0;
      end else if (btn_off_s) begin
        nxt_toggle = 1'b0;
        if (fault_clr) begin
          nxt_fault = 1'b0;
        end
        // Trip beats a same-cycle software clear
        if (unsafe_set) begin
          nxt_fault = 1'b1;
        end
      end else if (fault_clr) begin
        nxt_fault = 1'b0;
      end
      // Controller protect is a set, so it wins over a button toggle
      if (selected && pset_s) begin
        nxt_protect = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_ff <= 1'b0;
      fault_ff <= 1'b0;
      toggle_ff <= 1'b0;
    end else begin
      protect_ff <= nxt_protect;
      fault_ff <= nxt_fault;
      toggle_ff <= nxt_toggle;
    end
  end

  // Registered cable responses, drive internal controls and lamps
  logic [20:0] out_ff;
  logic [20:0] nxt_out;

  always_comb begin
    nxt_out = out_ff;
    if (ce) begin
      nxt_out[0] = selected;
      nxt_out[1] = selected && heads_loaded;
      nxt_out[2] = selected && unsafe;
      nxt_out[3] = selected && protect_ff;
      nxt_out[7:4] = sel_ready ? sector_count_in : 4'h0;
      nxt_out[8] = sel_ready && seek_settled_in;
      nxt_out[9] = sel_ready && seek_timeout_in;
      nxt_out[10] = sel_read && read_data_in;
      nxt_out[11] = sel_read && read_clock_in;
      nxt_out[12] = sel_write;
      nxt_out[13] = sel_write && no_motion;
      nxt_out[14] = sel_ready;
      nxt_out[15] = unsafe;
      nxt_out[16] = unsafe_set;
      nxt_out[17] = heads_loaded && no_motion;
      nxt_out[18] = sel_read;
      nxt_out[19] = sel_write;
      nxt_out[20] = protect_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign {protect_lamp, write_lamp, read_lamp, on_cyl_lamp, unsafe_trip,
          head_deselect, strobe_delay_en, write_toggle_en,
          selected_write_enable, read_clock_out, read_data_out,
          seek_timeout_resp, seek_settled_resp, sector_count_out,
          protect_status_resp, write_check_resp, file_ready_resp,
          density_flag_out} = out_ff;

  // APB slave: read data captured while the address is stable, so the
  // answer comes in the first access cycle unless ce was low at setup or in that cycle.
  logic cap_ff;
  logic nxt_cap;
  drive_sel_pkg::word_t rdata_ff;
  drive_sel_pkg::word_t nxt_rdata;
  logic mapped;

  assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS);
  assign pready = ce && psel && penable && cap_ff;
  assign pslverr = pready && !mapped;
  assign prdata = rdata_ff;
  assign wr_acc = pready && pwrite && mapped && pstrb[0];
  assign fault_clr = wr_acc && (paddr == `OFS_CTRL) && pstrb[1]
                     && pwdata[`CTRL_FAULT_CLR];

  always_comb begin
    nxt_cap = cap_ff;
    nxt_rdata = rdata_ff;
    nxt_unit = unit_ff;
    if (ce) begin
      nxt_cap = psel && !(penable && cap_ff);
      if (psel && !pwrite) begin
        nxt_rdata = '0;
        if (paddr == `OFS_CTRL) begin
          nxt_rdata[`CTRL_UNIT_MSB:`CTRL_UNIT_LSB] = unit_ff;
        end else if (paddr == `OFS_STATUS) begin
          nxt_rdata[`ST_SELECTED] = selected;
          nxt_rdata[`ST_SEL_READY] = sel_ready;
          nxt_rdata[`ST_PROTECT] = protect_ff;
          nxt_rdata[`ST_FAULT] = fault_ff;
          nxt_rdata[`ST_TOGGLE] = toggle_ff;
          nxt_rdata[`ST_UNSAFE] = unsafe;
          nxt_rdata[`ST_LOADED] = heads_loaded;
        end
      end
      if (wr_acc && paddr == `OFS_CTRL) begin
        nxt_unit = pwdata[`CTRL_UNIT_MSB:`CTRL_UNIT_LSB];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_ff <= 1'b0;
      rdata_ff <= '0;
      unit_ff <= `UNIT_RST;
    end else begin
      cap_ff <= nxt_cap;
      rdata_ff <= nxt_rdata;
      unit_ff <= nxt_unit;
    end
  end

  // Checks
  property p_on_cyl;
    @(posedge pclk) disable iff (!presetn)
    ce |=> (on_cyl_lamp == $past(heads_loaded && !fwd_req && !rev_req));
  endproperty
  a_on_cyl: assert property (p_on_cyl)
    else $error("on-cylinder lamp wrong");
  property p_resp_sel;
    @(posedge pclk) disable iff (!presetn)
    (ce && !selected) |=> !density_flag_out && !file_ready_resp
                         && !write_check_resp && !protect_status_resp;
  endproperty
  a_resp_sel: assert property (p_resp_sel)
    else $error("unselected drive answered");
  property p_gate_ready;
    @(posedge pclk) disable iff (!presetn)
    (ce && (!heads_loaded || fault_ff)) |=> sector_count_out == 4'h0
      && !seek_settled_resp && !seek_timeout_resp && !strobe_delay_en;
  endproperty
  a_gate_ready: assert property (p_gate_ready)
    else $error("response passed without select-ready");
  property p_prot_set;
    @(posedge pclk) disable iff (!presetn)
    (ce && selected && pset_s)
      |=> protect_ff ##1 (protect_lamp || !$past(ce));
  endproperty
  a_prot_set: assert property (p_prot_set)
    else $error("protect set ignored");
  property p_read;
    @(posedge pclk) disable iff (!presetn)
    (ce && !ren_s) |=> !read_lamp && !read_data_out && !read_clock_out;
  endproperty
  a_read: assert property (p_read)
    else $error("read gated without read enable");
  property p_write;
    @(posedge pclk) disable iff (!presetn)
    (ce && !wen_s) |=> !selected_write_enable && !write_toggle_en
      && !write_lamp;
  endproperty
  a_write: assert property (p_write)
    else $error("write gated without write enable");
  property p_unsafe;
    @(posedge pclk) disable iff (!presetn)
    (ce && write_current && !wen_s && btn_off_s && !btn_on_s)
      |=> fault_ff ##1 (head_deselect || !$past(ce));
  endproperty
  a_unsafe: assert property (p_unsafe)
    else $error("unsafe write did not set fault");
  property p_supply;
    @(posedge pclk) disable iff (!presetn)
    (ce && |supply_s) |=> head_deselect;
  endproperty
  a_supply: assert property (p_supply)
    else $error("heads not deselected on supply fault");
  property p_btn;
    @(posedge pclk) disable iff (!presetn)
    (ce && btn_on_s) |=> toggle_ff && !fault_ff;
  endproperty
  a_btn: assert property (p_btn)
    else $error("button press not handled");
  property p_once;
    @(posedge pclk) disable iff (!presetn)
    (ce && btn_on_s && toggle_ff && !(selected && pset_s))
      |=> $stable(protect_ff);
  endproperty
  a_once: assert property (p_once)
    else $error("protect toggled twice in one press");
endmodule : drive_select_status_logic

// [test/ctrl_model.sv]
// Disk controller model driving the drive's cable inputs
`timescale 1ns/1ps
module ctrl_model (
  // Clock
  input wire logic pclk,
  // Requests from the bench
  input wire logic [2:0] m_unit,
  input wire logic m_octal,
  input wire logic m_sel,
  input wire logic m_rd,
  input wire logic m_wr,
  input wire logic m_prot,
  // Cable lines
  output logic [3:0] drive_select_in = 4'h0,
  output logic octal_select_mode = 1'b0,
  output logic write_enable_in = 1'b0,
  output logic protect_set_in = 1'b0,
  output logic read_enable_in = 1'b0
);
  // Released lines are driven by the model itself to the inactive level, zero
  always @(posedge pclk) begin
    octal_select_mode <= m_octal;
    write_enable_in <= m_wr;
    read_enable_in <= m_rd;
    if (!m_sel)
      drive_select_in <= 4'h0;
    else if (m_octal)
      drive_select_in <= {1'b0, m_unit};
    else
      drive_select_in <= m_unit[2] ? 4'h0 : 4'h1 << m_unit[1:0];
    // Protect is only requested of the drive being addressed
    protect_set_in <= m_prot & m_sel;
  end
endmodule : ctrl_model

// [test/tb.sv]
// Self-checking bench for the drive select and status logic
`timescale 1ns/1ps
`include "drive_sel_defs.svh"
module tb;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [3:0] pstrb = 4'hF, drive_select_in, sector_count_in = 4'h0;
  logic octal_select_mode, write_enable_in, protect_set_in, read_enable_in;
  logic protect_button_pressed = 1'b0, protect_button_released = 1'b1;
  logic [2:0] supply_abnormal = 3'h0, m_unit = 3'h0;
  logic heads_loaded = 1'b0, fwd_req = 1'b0, rev_req = 1'b0, serr;
  logic write_current = 1'b0, read_data_in = 1'b0, read_clock_in = 1'b0;
  logic seek_settled_in = 1'b0, seek_timeout_in = 1'b0;
  logic density_flag_out, file_ready_resp, write_check_resp;
  logic protect_status_resp, seek_settled_resp, seek_timeout_resp;
  logic [3:0] sector_count_out;
  logic read_data_out, read_clock_out, selected_write_enable;
  logic write_toggle_en, strobe_delay_en, head_deselect, unsafe_trip;
  logic on_cyl_lamp, read_lamp, write_lamp, protect_lamp;
  logic m_octal = 1'b0, m_sel = 1'b0, m_rd = 1'b0, m_wr = 1'b0;
  logic m_prot = 1'b0;
  int n_errors = 0, cmp_count = 0;
  localparam logic [13:0] exp_g [6] = '{14'h2BFF, 14'h2B11, 14'h2BFB,
    14'h0000, 14'h0000, 14'h2BFB};

  always #4 pclk = ~pclk;

  ctrl_model u_ctrl (.pclk, .m_unit, .m_octal, .m_sel, .m_rd, .m_wr,
    .m_prot, .drive_select_in, .octal_select_mode, .write_enable_in,
    .protect_set_in, .read_enable_in);

  drive_select_status_logic u_dut (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .drive_select_in, .octal_select_mode, .write_enable_in, .protect_set_in,
    .read_enable_in, .protect_button_pressed, .protect_button_released,
    .supply_abnormal, .heads_loaded, .fwd_req, .rev_req, .write_current,
    .read_data_in, .read_clock_in, .sector_count_in, .seek_settled_in,
    .seek_timeout_in, .density_flag_out, .file_ready_resp, .write_check_resp,
    .protect_status_resp, .sector_count_out, .seek_settled_resp,
    .seek_timeout_resp, .read_data_out, .read_clock_out,
    .selected_write_enable, .write_toggle_en, .strobe_delay_en,
    .head_deselect, .unsafe_trip, .on_cyl_lamp, .read_lamp, .write_lamp,
    .protect_lamp);

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Values read at the edge are those settled in the cycle before it
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end else begin
      rdata = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // Two sync edges, one output edge, one model edge, plus margin
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask : settle

  task automatic press(input int n);
    protect_button_released <= 1'b0;
    protect_button_pressed <= 1'b1;
    repeat (n) @(posedge pclk);
    protect_button_pressed <= 1'b0;
    protect_button_released <= 1'b1;
    settle();
  endtask : press

  function automatic logic [13:0] gated();
    return {sector_count_out, seek_settled_resp, seek_timeout_resp,
      read_data_out, read_clock_out, read_lamp, strobe_delay_en,
      selected_write_enable, write_toggle_en, write_lamp, file_ready_resp};
  endfunction : gated

  task automatic regs();
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h5);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rdata, 32'h5);
    apb(1'b0, 8'h08, 32'h0);
    chk(serr, 1'b1);
    chk(rdata, 32'h0);
  endtask : regs

  task automatic sel_decode();
    logic e;
    heads_loaded <= 1'b1;
    m_sel <= 1'b1;
    for (int md = 0; md < 2; md++) begin
      m_octal <= md[0];
      for (int u = 0; u < 8; u++) begin
        apb(1'b1, `OFS_CTRL, u);
        for (int n = 0; n < 8; n++) begin
          m_unit <= n[2:0];
          settle();
          e = (n == u) && (md == 1 || u < 4);
          chk(density_flag_out, e);
          chk(file_ready_resp, e);
        end
      end
    end
    m_octal <= 1'b0;
  endtask : sel_decode

  task automatic gating();
    apb(1'b1, `OFS_CTRL, 32'h1);
    m_unit <= 3'h1;
    sector_count_in <= 4'hA;
    {seek_settled_in, seek_timeout_in} <= 2'b11;
    {read_data_in, read_clock_in} <= 2'b11;
    for (int k = 0; k < 6; k++) begin
      m_rd <= (k != 1);
      m_wr <= (k != 1);
      fwd_req <= (k == 2);
      rev_req <= (k == 5);
      heads_loaded <= (k != 3);
      m_sel <= (k != 4);
      settle();
      chk(gated(), exp_g[k]);
      chk(on_cyl_lamp, k != 2 && k != 3 && k != 5);
    end
  endtask : gating

  task automatic fault_protect();
    m_rd <= 1'b0;
    m_wr <= 1'b0;
    write_current <= 1'b1;
    settle();
    chk(unsafe_trip, 1'b1);
    chk(strobe_delay_en, 1'b0);
    chk(write_check_resp, 1'b1);
    write_current <= 1'b0;
    settle();
    chk(head_deselect, 1'b1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rdata[`ST_FAULT], 1'b1);
    press(40);
    chk(protect_lamp, 1'b1);
    chk(protect_status_resp, 1'b1);
    chk(head_deselect, 1'b0);
    press(4);
    chk(protect_lamp, 1'b0);
    write_current <= 1'b1;
    settle();
    chk(head_deselect, 1'b1);
    write_current <= 1'b0;
    apb(1'b1, `OFS_CTRL, 32'h101);
    settle();
    chk(head_deselect, 1'b0);
    m_prot <= 1'b1;
    settle();
    chk(protect_lamp, 1'b1);
    m_prot <= 1'b0;
    m_sel <= 1'b0;
    settle();
    chk(protect_status_resp, 1'b0);
  endtask : fault_protect

  task automatic supply();
    m_sel <= 1'b1;
    // A supply glitch that ends while the block is frozen must leave no trace
    ce <= 1'b0;
    supply_abnormal <= 3'h1;
    settle();
    chk(head_deselect, 1'b0);
    supply_abnormal <= 3'h0;
    ce <= 1'b1;
    settle();
    for (int b = 0; b < 3; b++) begin
      supply_abnormal <= 3'h1 << b;
      settle();
      chk(head_deselect, 1'b1);
      supply_abnormal <= 3'h0;
      settle();
    end
  endtask : supply

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    regs();
    sel_decode();
    gating();
    fault_protect();
    supply();
    report_and_stop();
  end
endmodule : tb
